// ===== core/dtp_core.sv
// digital-output trigger and timing engine with terminal debounce filters
// Function
// - sample clock is a divided internal or external timebase, or a terminal edge
// - the sample-clock timebase is never driven out of the block
// - start on trigger if configured, otherwise on software start command
// - programmable delay from start trigger to first sample, internal clock
// - start source: software pulse, terminal, ai ref, ai start, internal
// - digital start edge selectable rising or falling, only that edge starts
// - analog start uses first configured edge of comparison event
// - start may be scheduled at an absolute time
// - start trigger routed to a terminal is an active-high pulse
// - pause blocks new samples; a sample in progress completes
// - onboard clock resumes at once when pause deasserts
// - other clocks resume at the next sample-clock edge after deassert
// - digital pause from terminal or internal, pausing level selectable
// - analog pause holds samples while comparison is at configured level
// - each terminal individually an input or output of timing
// - each terminal input has its own enabled debounce filter
// - level change passes after N consecutive matching filter clock samples
// - short: 80 MHz clock, passes 112.5 ns, rejects 100 ns
// - medium 80 MHz passes 6.4 us; high 100 kHz passes 2.56 ms
// - custom: user filter clock and pass width
// - all filters disabled after reset until software enables them
// - sample clock routable to any terminal, active high
// - filtering applies to sample clock, start and pause inputs
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dtp_core
  import dtp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [dtp_pkg::NPFT-1:0] pft_in,
  output logic [dtp_pkg::NPFT-1:0] pft_out,
  output logic [dtp_pkg::NPFT-1:0] pft_oe,
  input wire logic ext_timebase,
  input wire logic ai_ref_trigger,
  input wire logic ai_start_trigger,
  input wire logic analog_cmp_event,
  input wire logic internal_start,
  input wire logic internal_pause,
  input wire logic [63:0] time_now,
  output logic out_sample_clock,
  output logic out_start_trigger,
  output logic running
);
  import dtp_pkg::*;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic edge_hit(input logic now, input logic prev,
                                    input logic falling);
    return falling ? (prev & ~now) : (now & ~prev);
  endfunction

  // ****************************************
  // register bus
  // ****************************************
  logic ack_q;
  logic [31:0] ctrl_q, timing_q, divisor_q, trig_q, delay_q;
  logic [31:0] time_lo_q, time_hi_q, filt_q, cust_clk_q, cust_n_q, route_q;
  logic [31:0] samples_q;
  logic [31:0] rdata_q;
  dtp_state_t state_q, state_d;
  wire acc_req = avs_read | avs_write;
  wire wr_go = avs_write & ~ack_q;
  wire wr_ctrl = wr_go && avs_address == A_CTRL;
  wire arm_cmd = wr_ctrl & avs_byteenable[0] & avs_writedata[0];
  wire stop_cmd = wr_ctrl & avs_byteenable[0] & avs_writedata[1];
  wire soft_pulse = wr_ctrl & avs_byteenable[0] & avs_writedata[2];
  assign avs_waitrequest = acc_req & ~ack_q;
  assign avs_readdata = rdata_q;

  logic [31:0] rd_mux;
  wire [31:0] status_word = {28'h0, running, 1'b0, state_q};
  always_comb begin
    if (avs_address == A_CTRL) begin
      rd_mux = status_word;
    end else if (avs_address == A_TIMING) begin
      rd_mux = timing_q;
    end else if (avs_address == A_DIVISOR) begin
      rd_mux = divisor_q;
    end else if (avs_address == A_TRIG) begin
      rd_mux = trig_q;
    end else if (avs_address == A_DELAY) begin
      rd_mux = delay_q;
    end else if (avs_address == A_TIME_LO) begin
      rd_mux = time_lo_q;
    end else if (avs_address == A_TIME_HI) begin
      rd_mux = time_hi_q;
    end else if (avs_address == A_FILT) begin
      rd_mux = filt_q;
    end else if (avs_address == A_CUST_CLK) begin
      rd_mux = cust_clk_q;
    end else if (avs_address == A_CUST_N) begin
      rd_mux = cust_n_q;
    end else if (avs_address == A_ROUTE) begin
      rd_mux = route_q;
    end else if (avs_address == A_SAMPLES) begin
      rd_mux = samples_q;
    end else begin
      rd_mux = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      timing_q <= 32'h0;
      divisor_q <= {16'h0, DIVISOR_RST};
      trig_q <= 32'h0;
      delay_q <= 32'h0;
      time_lo_q <= 32'h0;
      time_hi_q <= 32'h0;
      filt_q <= 32'h0;
      cust_clk_q <= {CUST_DEN_RST, CUST_NUM_RST};
      cust_n_q <= {16'h0, CUST_N_RST};
      route_q <= 32'h0;
    end else begin
      ack_q <= acc_req & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= rd_mux;
      end
      if (wr_go) begin
        if (avs_address == A_TIMING) begin
          timing_q <= merge(timing_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_DIVISOR) begin
          divisor_q <= merge(divisor_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_TRIG) begin
          trig_q <= merge(trig_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_DELAY) begin
          delay_q <= merge(delay_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_TIME_LO) begin
          time_lo_q <= merge(time_lo_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_TIME_HI) begin
          time_hi_q <= merge(time_hi_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_FILT) begin
          filt_q <= merge(filt_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_CUST_CLK) begin
          cust_clk_q <= merge(cust_clk_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_CUST_N) begin
          cust_n_q <= merge(cust_n_q, avs_writedata, avs_byteenable);
        end else if (avs_address == A_ROUTE) begin
          route_q <= merge(route_q, avs_writedata, avs_byteenable);
        end
      end
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NSYNC = NPFT + 4;
  logic [NSYNC-1:0] sync1_q, sync2_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {analog_cmp_event, ai_start_trigger, ai_ref_trigger,
                  ext_timebase, pft_in};
      sync2_q <= sync1_q;
    end
  end
  wire [NPFT-1:0] pft_s = sync2_q[NPFT-1:0];
  wire tb_s = sync2_q[NPFT];
  wire ai_ref_s = sync2_q[NPFT+1];
  wire ai_start_s = sync2_q[NPFT+2];
  wire acmp_s = sync2_q[NPFT+3];

  // ****************************************
  // debounce filters
  // ****************************************
  wire [NPFT-1:0] filt_en = filt_q[NPFT-1:0];
  wire dtp_filt_t filt_set = dtp_filt_t'(filt_q[9:8]);
  wire [15:0] fc_num = filt_set == F_HIGH ? SLOW_NUM :
                       filt_set == F_CUSTOM ? cust_clk_q[15:0] : FAST_NUM;
  wire [15:0] fc_den = filt_set == F_HIGH ? SLOW_DEN :
                       filt_set == F_CUSTOM ? cust_clk_q[31:16] : FAST_DEN;
  wire [15:0] filt_n = filt_set == F_SHORT ? N_SHORT :
                       filt_set == F_MEDIUM ? N_MEDIUM :
                       filt_set == F_HIGH ? N_HIGH : cust_n_q[15:0];
  logic [15:0] facc_q;
  wire [16:0] facc_sum = {1'b0, facc_q} + {1'b0, fc_num};
  wire fclk_tick = facc_sum >= {1'b0, fc_den};
  logic [NPFT-1:0] passed_q;
  logic [15:0] fcnt_q [NPFT];
  always_ff @(posedge clk) begin
    if (reset) begin
      facc_q <= 16'h0;
      passed_q <= '0;
      for (int i = 0; i < NPFT; i++) begin
        fcnt_q[i] <= 16'h0;
      end
    end else begin
      facc_q <= fclk_tick ? 16'(facc_sum - {1'b0, fc_den}) : facc_sum[15:0];
      for (int i = 0; i < NPFT; i++) begin
        if (!filt_en[i]) begin
          passed_q[i] <= pft_s[i];
          fcnt_q[i] <= 16'h0;
        end else if (fclk_tick) begin
          if (pft_s[i] == passed_q[i]) begin
            fcnt_q[i] <= 16'h0;
          end else if (fcnt_q[i] + 16'h1 >= filt_n) begin
            passed_q[i] <= pft_s[i];
            fcnt_q[i] <= 16'h0;
          end else begin
            fcnt_q[i] <= fcnt_q[i] + 16'h1;
          end
        end
      end
    end
  end
  // filtered view feeds every terminal consumer
  wire [NPFT-1:0] pft_f = passed_q;

  // ****************************************
  // sample clock generation
  // ****************************************
  wire dtp_sclk_t sc_src = dtp_sclk_t'(timing_q[1:0]);
  wire [2:0] sc_pft = timing_q[6:4];
  wire onboard = sc_src == SC_ONBOARD;
  logic tb_prev_q, scp_prev_q, pause_prev_q;
  logic [15:0] div_q;
  logic [3:0] hi_q;
  // the timebase stays internal: no port carries it
  wire tb_tick = onboard ? 1'b1 : (tb_s & ~tb_prev_q);
  wire div_wrap = div_q + 16'h1 >= divisor_q[15:0];
  wire scp_now = pft_f[sc_pft];
  wire sc_tick = sc_src == SC_PFT ? (scp_now & ~scp_prev_q) :
                 (tb_tick & div_wrap);

  // ****************************************
  // start and pause selection
  // ****************************************
  wire dtp_start_t st_src = dtp_start_t'(trig_q[2:0]);
  wire st_fall = trig_q[3];
  wire [2:0] st_pft = trig_q[6:4];
  wire dtp_pause_t ps_src = dtp_pause_t'(trig_q[9:8]);
  wire ps_level = trig_q[10];
  wire [2:0] ps_pft = trig_q[14:12];
  logic st_prev_q;
  wire st_level = st_src == ST_PFT ? pft_f[st_pft] :
                  st_src == ST_AI_REF ? ai_ref_s :
                  st_src == ST_AI_START ? ai_start_s :
                  st_src == ST_ANALOG ? acmp_s :
                  internal_start;
  wire time_hit = time_now >= {time_hi_q, time_lo_q};
  wire trig_hit = st_src == ST_SOFT ? soft_pulse :
                  st_src == ST_TIME ? time_hit :
                  edge_hit(st_level, st_prev_q, st_fall);
  wire ps_in = ps_src == PS_PFT ? pft_f[ps_pft] :
               ps_src == PS_INTERNAL ? internal_pause : acmp_s;
  wire pause_act = ps_src != PS_NONE && ps_in == ps_level;
  // a fresh edge must follow deassertion for non-onboard clocks
  wire resume_ok = onboard | ~pause_prev_q;
  wire sample_fire = state_q == S_RUN && sc_tick && !pause_act && resume_ok;

  // ****************************************
  // generation state machine
  // ****************************************
  logic [31:0] dly_q;
  wire use_delay = sc_src != SC_PFT && delay_q != 32'h0;
  wire dtp_state_t go_state = use_delay ? S_DELAY : S_RUN;
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (arm_cmd) begin
          state_d = st_src == ST_NONE ? go_state : S_ARMED;
        end
      end
      S_ARMED: begin
        if (trig_hit) begin
          state_d = go_state;
        end
      end
      S_DELAY: begin
        if (dly_q + 32'h1 >= delay_q) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        state_d = S_RUN;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (stop_cmd) begin
      state_d = S_IDLE;
    end
  end

  wire start_event = (state_q == S_ARMED || state_q == S_IDLE) &&
                     (state_d == S_RUN || state_d == S_DELAY);
  logic start_pulse_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      dly_q <= 32'h0;
      div_q <= 16'h0;
      hi_q <= 4'h0;
      tb_prev_q <= 1'b0;
      scp_prev_q <= 1'b0;
      st_prev_q <= 1'b0;
      pause_prev_q <= 1'b0;
      start_pulse_q <= 1'b0;
      samples_q <= 32'h0;
    end else begin
      state_q <= state_d;
      tb_prev_q <= tb_s;
      scp_prev_q <= scp_now;
      st_prev_q <= st_level;
      pause_prev_q <= pause_act;
      start_pulse_q <= start_event;
      dly_q <= state_q == S_DELAY ? dly_q + 32'h1 : 32'h0;
      if (state_q != S_RUN) begin
        div_q <= 16'h0;
      end else if (tb_tick && !(pause_act && onboard)) begin
        div_q <= div_wrap ? 16'h0 : div_q + 16'h1;
      end
      // a running pulse completes even when pause arrives
      if (sample_fire) begin
        hi_q <= SC_HIGH;
        samples_q <= samples_q + 32'h1;
      end else if (hi_q != 4'h0) begin
        hi_q <= hi_q - 4'h1;
      end
      if (arm_cmd && state_q == S_IDLE) begin
        samples_q <= 32'h0;
      end
    end
  end

  // ****************************************
  // outputs and terminal routing
  // ****************************************
  logic sclk_out_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_out_q <= 1'b0;
    end else begin
      sclk_out_q <= sample_fire | (hi_q > 4'h1);
    end
  end
  assign out_sample_clock = sclk_out_q;
  assign out_start_trigger = start_pulse_q;
  assign running = state_q == S_RUN;
  // per terminal direction and source
  assign pft_oe = route_q[NPFT-1:0];
  always_comb begin
    for (int i = 0; i < NPFT; i++) begin
      pft_out[i] = route_q[8+i] ? start_pulse_q : sclk_out_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_soft_arm;
    state_q == S_IDLE && arm_cmd && !stop_cmd && st_src == ST_NONE;
  endsequence
  property p_soft_start;
    @(posedge clk) disable iff (reset)
    s_soft_arm |=> state_q == S_RUN || state_q == S_DELAY;
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("software start did not begin generation");

  property p_armed_wait;
    @(posedge clk) disable iff (reset)
    state_q == S_ARMED && !trig_hit && !stop_cmd |=> state_q == S_ARMED;
  endproperty
  a_armed_wait: assert property (p_armed_wait)
    else $error("generation began without the configured edge");

  property p_pause_block;
    @(posedge clk) disable iff (reset)
    pause_act |-> !sample_fire;
  endproperty
  a_pause_block: assert property (p_pause_block)
    else $error("sample issued while paused");

  property p_pulse_len;
    @(posedge clk) disable iff (reset)
    sample_fire |=> out_sample_clock [*2];
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("sample clock pulse cut short");

  property p_ext_resume;
    @(posedge clk) disable iff (reset)
    !onboard && $fell(pause_act) |-> !sample_fire;
  endproperty
  a_ext_resume: assert property (p_ext_resume)
    else $error("external clock resumed without a fresh edge");

  property p_start_pulse;
    @(posedge clk) disable iff (reset)
    start_event |=> out_start_trigger ##1 !out_start_trigger;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start trigger output is not a single pulse");

  property p_filt_off;
    @(posedge clk) $past(reset) && !reset |-> filt_en == '0;
  endproperty
  a_filt_off: assert property (p_filt_off)
    else $error("filters enabled after reset");

  property p_filt_hold;
    @(posedge clk) disable iff (reset)
    filt_en[1] && fclk_tick && fcnt_q[1] + 16'h1 < filt_n
      |=> $stable(passed_q[1]);
  endproperty
  a_filt_hold: assert property (p_filt_hold)
    else $error("filter passed a change before N samples");

  property p_bus_answer;
    @(posedge clk) disable iff (reset)
    acc_req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus access not answered in one cycle");
endmodule

// ===== core/dtp_pkg.sv
// package: constants, register map and types of the trigger/filter block
package dtp_pkg;
  localparam int NPFT = 8;
  localparam int CLK_MHZ = 250;
  // register byte offsets
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_TIMING = 6'h04;
  localparam logic [5:0] A_DIVISOR = 6'h08;
  localparam logic [5:0] A_TRIG = 6'h0c;
  localparam logic [5:0] A_DELAY = 6'h10;
  localparam logic [5:0] A_TIME_LO = 6'h14;
  localparam logic [5:0] A_TIME_HI = 6'h18;
  localparam logic [5:0] A_FILT = 6'h1c;
  localparam logic [5:0] A_CUST_CLK = 6'h20;
  localparam logic [5:0] A_CUST_N = 6'h24;
  localparam logic [5:0] A_ROUTE = 6'h28;
  localparam logic [5:0] A_SAMPLES = 6'h2c;
  // reset values
  localparam logic [15:0] DIVISOR_RST = 16'h0019;
  localparam logic [15:0] CUST_NUM_RST = 16'h0001;
  localparam logic [15:0] CUST_DEN_RST = 16'h0001;
  localparam logic [15:0] CUST_N_RST = 16'h0005;
  // filter clocks as fractions of the 250 MHz chassis timebase
  localparam logic [15:0] FAST_NUM = 16'h0008; // 80 MHz = 8/25
  localparam logic [15:0] FAST_DEN = 16'h0019;
  localparam logic [15:0] SLOW_NUM = 16'h0001; // 100 kHz = 1/2500
  localparam logic [15:0] SLOW_DEN = 16'h09c4;
  // consecutive filter clock edges needed per setting
  localparam real SHORT_NS = 112.5;
  localparam real MEDIUM_NS = 6400.0;
  localparam real HIGH_NS = 2560000.0;
  localparam logic [15:0] N_SHORT = 16'(int'(SHORT_NS * 80.0 / 1000.0));
  localparam logic [15:0] N_MEDIUM = 16'(int'(MEDIUM_NS * 80.0 / 1000.0));
  localparam logic [15:0] N_HIGH = 16'(int'(HIGH_NS * 0.1 / 1000.0));
  // width of the output sample clock pulse in cycles
  localparam logic [3:0] SC_HIGH = 4'h2;
  typedef enum logic [1:0] {
    F_SHORT = 2'h0, F_MEDIUM = 2'h1, F_HIGH = 2'h2, F_CUSTOM = 2'h3
  } dtp_filt_t;
  typedef enum logic [1:0] {
    SC_ONBOARD = 2'h0, SC_EXT_TB = 2'h1, SC_PFT = 2'h2
  } dtp_sclk_t;
  typedef enum logic [2:0] {
    ST_NONE = 3'h0, ST_SOFT = 3'h1, ST_PFT = 3'h2, ST_AI_REF = 3'h3,
    ST_AI_START = 3'h4, ST_ANALOG = 3'h5, ST_INTERNAL = 3'h6, ST_TIME = 3'h7
  } dtp_start_t;
  typedef enum logic [1:0] {
    PS_NONE = 2'h0, PS_PFT = 2'h1, PS_INTERNAL = 2'h2, PS_ANALOG = 2'h3
  } dtp_pause_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_ARMED = 2'h1, S_DELAY = 2'h3, S_RUN = 2'h2
  } dtp_state_t;
endpackage

// ===== verif/dtp_core_tb.sv
// self-checking bench of the trigger and filter block
`timescale 1ns/1ps
module dtp_core_tb;
  import dtp_pkg::*;
  logic clk, reset, rd, wr, wq, sclk, strt, run, pz;
  logic [5:0] adr;
  logic [31:0] wd, rdata, q;
  logic [7:0] pout, poe, pin, drv;
  logic [3:0] lv;
  logic [63:0] tnow, t0;
  int failures, check_count, n, w, r, d, spc, ppc, s0, p0;
  int src[5] = '{3, 4, 5, 6, 2};
  dtp_core dut(.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wq), .pft_in(pin),
    .pft_out(pout), .pft_oe(poe), .ext_timebase(1'b0),
    .ai_ref_trigger(lv[0]), .ai_start_trigger(lv[1]),
    .analog_cmp_event(lv[2]), .internal_start(lv[3]), .internal_pause(pz),
    .time_now(tnow), .out_sample_clock(sclk), .out_start_trigger(strt),
    .running(run));
  dtp_pft_model pm(.drv(drv), .pft_out(pout), .pft_oe(poe), .pft_in(pin));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    tnow <= tnow + 64'h1;
    if (strt === 1'b1) spc <= spc + 1;
    if (pout[2] === 1'b1 && poe[2] === 1'b1) ppc <= ppc + 1;
  end
  // ****************
  // tasks
  // ****************
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w_, input logic [5:0] a, input logic [31:0] dd);
    int k;
    @(posedge clk);
    adr <= a; wr <= w_; rd <= !w_; wd <= dd;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 20);
    q = rdata;
    if (k >= 20) failures++;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task wrun(input int lim);
    n = 0;
    while (run !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  // wait for a sample, then its width and the spacing to the next one
  task per();
    r = 0;
    while (sclk !== 1'b1 && r < 60) begin
      @(posedge clk);
      r++;
    end
    w = 0;
    while (sclk === 1'b1 && w < 60) begin
      @(posedge clk);
      w++;
    end
    n = w;
    while (sclk !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
  endtask
  task cnt(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      if (sclk === 1'b1) n++;
    end
  endtask
  task set(input int i, input logic v);
    if (i == 4) drv[1] <= v;
    else lv[i] <= v;
  endtask
  task give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    clk = 0; reset = 1; rd = 0; wr = 0; adr = 0; wd = 0; drv = 0; lv = 0;
    pz = 0; tnow = 0; failures = 0; check_count = 0; spc = 0; ppc = 0;
    void'($urandom(32'h5f08));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    bus(0, A_FILT, 0);
    chk("filt_reset", q, 32'h0);
    bus(0, A_DIVISOR, 0);
    chk("div_reset", q, {16'h0, DIVISOR_RST});
    bus(1, 6'h30, 32'hffff_ffff);
    bus(0, 6'h30, 0);
    chk("unmapped", q, 32'h0);
    bus(1, A_ROUTE, 32'h0000_0404);
    repeat (3) begin
      d = $urandom_range(10, 3);
      bus(1, A_CTRL, 2); bus(1, A_DIVISOR, d);
      bus(1, A_TRIG, 0); bus(1, A_CTRL, 1);
      per();
      chk("sc_width", w, SC_HIGH);
      chk("sc_period", n, d);
    end
    $display("test divider done");
    bus(1, A_TRIG, 32'h600);
    pz <= 1'b1;
    repeat (4) @(posedge clk);
    cnt(3 * d);
    chk("paused_high", n, 0);
    pz <= 1'b0;
    per();
    chk("resume", r <= d + 3, 1);
    bus(1, A_TRIG, 32'h200);
    repeat (4) @(posedge clk);
    cnt(3 * d);
    chk("paused_low", n, 0);
    pz <= 1'b1;
    per();
    chk("resume_low", r <= d + 3, 1);
    $display("test pause done");
    bus(1, A_CTRL, 2); bus(1, A_DELAY, 20); bus(1, A_TRIG, 0);
    bus(1, A_CTRL, 1);
    wrun(60);
    chk("delay", n >= 17 && n <= 24, 1);
    bus(1, A_DELAY, 0);
    for (int i = 0; i < 5; i++) begin
      bus(1, A_CTRL, 2); bus(1, A_TRIG, src[i] | 32'h18); bus(1, A_CTRL, 1);
      set(i, 1'b1);
      wrun(12);
      chk("wrong_edge", run, 0);
      s0 = spc; p0 = ppc;
      set(i, 1'b0);
      wrun(12);
      chk("start", run, 1);
      repeat (2) @(posedge clk);
      chk("start_pulse", spc - s0, 1);
      chk("pin_pulse", ppc - p0, 1);
    end
    bus(1, A_CTRL, 2); bus(1, A_TRIG, 1); bus(1, A_CTRL, 1);
    wrun(8);
    chk("soft_wait", run, 0);
    bus(1, A_CTRL, 4);
    wrun(8);
    chk("soft_start", run, 1);
    $display("test start sources done");
    bus(1, A_CTRL, 2); bus(1, A_TRIG, 7);
    t0 = tnow + 64'd60;
    bus(1, A_TIME_LO, t0[31:0]); bus(1, A_TIME_HI, t0[63:32]);
    bus(1, A_CTRL, 1);
    wrun(100);
    chk("time_start", tnow >= t0 && tnow <= t0 + 64'd4, 1);
    $display("test time start done");
    bus(1, A_CTRL, 2); bus(1, A_FILT, 32'h302);
    bus(1, A_CUST_CLK, 32'h0001_0001); bus(1, A_CUST_N, 5);
    bus(1, A_TRIG, 32'h12); bus(1, A_CTRL, 1);
    repeat (2) begin
      drv[1] <= 1'b1;
      repeat (3) @(posedge clk);
      drv[1] <= 1'b0;
      @(posedge clk);
    end
    wrun(12);
    chk("glitch", run, 0);
    drv[1] <= 1'b1;
    wrun(20);
    chk("filtered", run, 1);
    chk("filt_delay", n >= 5, 1);
    $display("test filter done");
    bus(1, A_CTRL, 2); bus(1, A_FILT, 0); bus(1, A_TIMING, 32'h12);
    bus(1, A_TRIG, 32'h600); bus(1, A_CTRL, 1);
    n = 0;
    repeat (16) begin
      drv[1] <= ~drv[1];
      repeat (4) begin
        @(posedge clk);
        if (sclk === 1'b1) n++;
      end
    end
    chk("ext_paused", n, 0);
    pz <= 1'b0;
    n = 0;
    repeat (4) begin
      drv[1] <= ~drv[1];
      repeat (4) begin
        @(posedge clk);
        if (sclk === 1'b1) n++;
      end
    end
    repeat (8) begin
      @(posedge clk);
      if (sclk === 1'b1) n++;
    end
    chk("ext_resume", n, 4);
    $display("test terminal clock done");
    give_verdict();
  end
endmodule

// ===== verif/dtp_pft_model.sv
// model of the plug-in modules that drive the terminal pins
`timescale 1ns/1ps
module dtp_pft_model
  import dtp_pkg::*;
(
  input wire logic [dtp_pkg::NPFT-1:0] drv,
  input wire logic [dtp_pkg::NPFT-1:0] pft_out,
  input wire logic [dtp_pkg::NPFT-1:0] pft_oe,
  output logic [dtp_pkg::NPFT-1:0] pft_in
);
  // each pin follows whichever side drives it, per terminal
  assign pft_in = (pft_oe & pft_out) | (~pft_oe & drv);
endmodule
